// ===== rtl/isp_port.sv
`timescale 1ns/1ns
//Contract
//- flash pages of 16/32 words, 64/128 pages
//- eeprom pages of 4 bytes, low bits byte
//- programming only while reset pin low
//- programming enable must come first
//- eeprom writes erase automatically
//- chip erase sets flash and eeprom to ones
//- mosi sampled on rising sck
//- miso shifted on falling sck
//- second enable byte echoed during third byte
//- load page byte with low address bits
//- page write commits buffer to chosen page
//- eeprom byte write erases then writes
//- eeprom page write changes loaded bytes only
//- read returns addressed memory content
//- reset pin high ends programming mode
//- poll returns pending flag in lsb
//- flash addresses are word addresses
module isp_port
  import isp_pkg::*;
#(
  parameter int FLASH_WAIT = FLASH_WAIT_CYC,
  parameter int EE_WAIT    = EE_WAIT_CYC,
  parameter int ERASE_WAIT = ERASE_WAIT_CYC
)
(
  // system
  input  wire logic clk,
  input  wire logic reset,
  // programming pins
  input  wire logic reset_pin_n,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  // status
  output logic      prog_enabled,
  output logic      write_pending_flag,
  output logic      run_normal
);
  localparam logic [WAIT_W-1:0] FLASH_LOAD = WAIT_W'(FLASH_WAIT - 1);
  localparam logic [WAIT_W-1:0] EE_LOAD    = WAIT_W'(EE_WAIT - 1);
  localparam logic [WAIT_W-1:0] ERASE_LOAD = WAIT_W'(ERASE_WAIT - 1);

  function automatic logic [FLASH_WORD_AW-1:0] word_addr(input logic [15:0] f);
    word_addr = f[FLASH_WORD_AW-1:0];
  endfunction : word_addr

  isp_link_if lk();

  isp_link u_link (
    .sck  (sck),
    .mosi (mosi),
    .miso (miso),
    .lk   (lk)
  );

  logic                     pin_s1_r;
  logic                     pin_s2_r;
  logic                     hdr_s1_r;
  logic                     hdr_s2_r;
  logic                     hdr_s3_r;
  logic                     cmd_s1_r;
  logic                     cmd_s2_r;
  logic                     cmd_s3_r;
  logic                     sess_r;
  logic                     link_clear_r;
  logic                     enabled_r;
  logic                     act_hdr_r;
  logic                     rd_go_r;
  logic                     act_cmd_r;
  logic [23:0]              hdr_c_r;
  logic [31:0]              cmd_c_r;
  logic [7:0]               resp_r;
  isp_state_type            st_r;
  isp_state_type            st_nxt;
  logic [SWEEP_W-1:0]       sw_r;
  logic [SWEEP_W-1:0]       sw_nxt;
  logic [WAIT_W-1:0]        wait_r;
  logic [WAIT_W-1:0]        wait_nxt;
  logic [PAGE_IDX_W-1:0]    page_r;
  logic [FBUF_BYTES-1:0]    fmask_r;
  logic [EE_PAGE_BYTES-1:0] ee_mask_r;
  logic [7:0]               ee_buf_r [EE_PAGE_BYTES];
  logic [7:0]               fl_rdata;
  logic [7:0]               ee_rdata;
  logic [7:0]               fbuf_rdata;

  // clock-domain crossing: pin level and two event toggles
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      hdr_s1_r <= 1'b0;
      hdr_s2_r <= 1'b0;
      hdr_s3_r <= 1'b0;
      cmd_s1_r <= 1'b0;
      cmd_s2_r <= 1'b0;
      cmd_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
      hdr_s1_r <= lk.hdr_tog;
      hdr_s2_r <= hdr_s1_r;
      hdr_s3_r <= hdr_s2_r;
      cmd_s1_r <= lk.cmd_tog;
      cmd_s2_r <= cmd_s1_r;
      cmd_s3_r <= cmd_s2_r;
    end
  end

  wire hdr_ev = hdr_s2_r ^ hdr_s3_r;
  wire cmd_ev = cmd_s2_r ^ cmd_s3_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sess_r       <= 1'b0;
      link_clear_r <= 1'b1;
      act_hdr_r    <= 1'b0;
      rd_go_r      <= 1'b0;
      act_cmd_r    <= 1'b0;
      hdr_c_r      <= 24'h000000;
      cmd_c_r      <= 32'h00000000;
    end
    else
    begin
      sess_r       <= ~pin_s2_r;
      link_clear_r <= pin_s2_r;
      act_hdr_r    <= hdr_ev;
      rd_go_r      <= act_hdr_r;
      act_cmd_r    <= cmd_ev;
      if (hdr_ev)
        hdr_c_r <= lk.hdr_word;
      if (cmd_ev)
        cmd_c_r <= lk.cmd_word;
    end
  end

  assign lk.link_clear = link_clear_r;
  assign lk.resp_byte  = resp_r;

  // header fields, known after byte 3
  wire [7:0]  h_op   = hdr_c_r[23:16];
  wire [15:0] h_addr = hdr_c_r[15:0];
  wire        h_rdfl = (h_op == OP_READ_LO) || (h_op == OP_READ_HI);
  wire [FLASH_BYTE_AW-1:0] fl_raddr = {word_addr(h_addr), h_op == OP_READ_HI};
  wire [EE_AW-1:0]         ee_raddr = h_addr[EE_AW-1:0];

  // whole-instruction fields
  wire [7:0]  c_op   = cmd_c_r[31:24];
  wire [7:0]  c_b2   = cmd_c_r[23:16];
  wire [15:0] c_addr = cmd_c_r[23:8];
  wire [7:0]  c_data = cmd_c_r[7:0];
  wire        is_pe  = (c_op == OP_PROG_EN) && (c_b2 == OP_PE_SECOND);
  wire        busy   = (st_r != ST_IDLE);
  wire        go     = act_cmd_r && enabled_r && !busy;

  wire do_erase      = go && (c_op == OP_PROG_EN) && (c_b2 == OP_ERASE_SEC);
  wire do_load_f     = go && ((c_op == OP_LOAD_LO) || (c_op == OP_LOAD_HI));
  wire do_load_ee    = go && (c_op == OP_LOAD_EE);
  wire do_wr_page    = go && (c_op == OP_WR_PAGE);
  wire do_wr_ee      = go && (c_op == OP_WR_EE);
  wire do_wr_ee_page = go && (c_op == OP_WR_EE_PAGE);

  wire [FLASH_WORD_AW-1:0] c_waddr = word_addr(c_addr);
  wire [PAGE_IDX_W-1:0]    c_fpage = c_waddr[FLASH_WORD_AW-1:WORD_IDX_W];
  wire [PAGE_IDX_W-1:0] c_epage = c_addr[EE_AW-1:EE_BYTE_IDX_W];

  // page buffer load: word index plus high/low select
  wire [FBUF_AW-1:0] fbuf_waddr = {c_addr[WORD_IDX_W-1:0], c_op == OP_LOAD_HI};

  // commit and erase sweep drive the array write ports
  wire [FBUF_AW-1:0]       fl_idx   = sw_r[FBUF_AW-1:0] - FBUF_AW'(1);
  wire [EE_BYTE_IDX_W-1:0] ee_sw    = sw_r[EE_BYTE_IDX_W-1:0];
  wire                     in_erase = (st_r == ST_ERASE);
  wire                     in_eepg  = (st_r == ST_EE_PAGE);

  wire fl_we = in_erase || ((st_r == ST_FLASH_WR) && (sw_r != '0));
  wire [FLASH_BYTE_AW-1:0] fl_waddr = in_erase ? sw_r : {page_r, fl_idx};
  // unloaded buffer bytes are written as erased
  wire [7:0] fl_wdata = (!in_erase && fmask_r[fl_idx]) ? fbuf_rdata : ERASED_BYTE;

  wire ee_we = (in_erase && (sw_r < EE_LIMIT)) || (in_eepg && ee_mask_r[ee_sw])
               || do_wr_ee;
  wire [EE_AW-1:0] ee_waddr = in_erase ? sw_r[EE_AW-1:0] :
                              in_eepg  ? {page_r, ee_sw} : c_addr[EE_AW-1:0];
  wire [7:0]       ee_wdata = in_erase ? ERASED_BYTE :
                              in_eepg  ? ee_buf_r[ee_sw] : c_data;

  // answer for byte 4; reads need a pause after byte 3
  wire [7:0] resp_nxt = (h_op == OP_POLL)    ? {7'h00, busy} :
                        h_rdfl               ? fl_rdata      :
                        (h_op == OP_READ_EE) ? ee_rdata      :
                                               hdr_c_r[7:0];

  isp_mem #(.AW(FLASH_BYTE_AW), .DW(8)) u_flash (
    .clk   (clk),
    .we    (fl_we),
    .waddr (fl_waddr),
    .wdata (fl_wdata),
    .raddr (fl_raddr),
    .rdata (fl_rdata)
  );

  isp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
    .clk   (clk),
    .we    (ee_we),
    .waddr (ee_waddr),
    .wdata (ee_wdata),
    .raddr (ee_raddr),
    .rdata (ee_rdata)
  );

  isp_mem #(.AW(FBUF_AW), .DW(8)) u_fbuf (
    .clk   (clk),
    .we    (do_load_f),
    .waddr (fbuf_waddr),
    .wdata (c_data),
    .raddr (sw_r[FBUF_AW-1:0]),
    .rdata (fbuf_rdata)
  );

  always_comb
  begin
    st_nxt   = st_r;
    sw_nxt   = sw_r + SWEEP_W'(1);
    wait_nxt = wait_r;
    case (st_r)
      ST_IDLE:
      begin
        sw_nxt = '0;
        if (do_erase)
          st_nxt = ST_ERASE;
        else if (do_wr_page)
          st_nxt = ST_FLASH_WR;
        else if (do_wr_ee_page)
          st_nxt = ST_EE_PAGE;
        else if (do_wr_ee)
        begin
          st_nxt   = ST_WAIT;
          wait_nxt = EE_LOAD;
        end
      end
      ST_ERASE:
        if (sw_r == ERASE_LAST)
        begin
          st_nxt   = ST_WAIT;
          wait_nxt = ERASE_LOAD;
        end
      ST_FLASH_WR:
        if (sw_r == FBUF_LAST)
        begin
          st_nxt   = ST_WAIT;
          wait_nxt = FLASH_LOAD;
        end
      ST_EE_PAGE:
        if (sw_r == EE_PAGE_LAST)
        begin
          st_nxt   = ST_WAIT;
          wait_nxt = EE_LOAD;
        end
      ST_WAIT:
      begin
        sw_nxt = '0;
        if (wait_r == '0)
          st_nxt = ST_IDLE;
        else
          wait_nxt = wait_r - WAIT_W'(1);
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r      <= ST_IDLE;
      sw_r      <= '0;
      wait_r    <= '0;
      page_r    <= '0;
      enabled_r <= 1'b0;
      resp_r    <= 8'h00;
    end
    else
    begin
      st_r   <= st_nxt;
      sw_r   <= sw_nxt;
      wait_r <= wait_nxt;
      if (do_wr_page)
        page_r <= c_fpage;
      else if (do_wr_ee_page)
        page_r <= c_epage;
      if (!sess_r)
        enabled_r <= 1'b0;
      else if (act_cmd_r && is_pe)
        enabled_r <= 1'b1;
      if (rd_go_r)
        resp_r <= resp_nxt;
    end
  end

  // a load in the cycle a commit ends still keeps its mark
  always_ff @(posedge clk)
  begin
    if (reset)
      fmask_r <= '0;
    else
    begin
      if ((st_r == ST_FLASH_WR) && (sw_r == FBUF_LAST))
        fmask_r <= '0;
      if (do_load_f)
        fmask_r[fbuf_waddr] <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < EE_PAGE_BYTES; gi++)
    begin : g_ee_buf
      wire hit = do_load_ee && (c_addr[EE_BYTE_IDX_W-1:0] == EE_BYTE_IDX_W'(gi));
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          ee_buf_r[gi]  <= 8'h00;
          ee_mask_r[gi] <= 1'b0;
        end
        else if (hit)
        begin
          ee_buf_r[gi]  <= c_data;
          ee_mask_r[gi] <= 1'b1;
        end
        else if (in_eepg && (sw_r == EE_PAGE_LAST))
          ee_mask_r[gi] <= 1'b0;
      end
    end
  endgenerate

  assign miso_oe            = sess_r;
  assign prog_enabled       = enabled_r;
  assign write_pending_flag = busy;
  assign run_normal         = ~sess_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_flash_sweep;
    (st_r == ST_FLASH_WR)[*8];
  endsequence

  property p_pe_gate;
    act_cmd_r && !enabled_r && !busy |-> !ee_we && !do_load_f ##1 (st_r == $past(st_r));
  endproperty
  a_pe_gate: assert property (p_pe_gate) else $error("command ran before enable");

  property p_pe_accept;
    act_cmd_r && is_pe && sess_r |=> enabled_r;
  endproperty
  a_pe_accept: assert property (p_pe_accept) else $error("enable not accepted");

  property p_erase;
    do_erase |=> (in_erase && fl_we && (fl_wdata == ERASED_BYTE)
                  && ee_we && (ee_wdata == ERASED_BYTE))[*4];
  endproperty
  a_erase: assert property (p_erase) else $error("erase not writing ones");

  property p_flash_commit;
    do_wr_page |=> (page_r == $past(c_fpage)) ##0 s_flash_sweep;
  endproperty
  a_flash_commit: assert property (p_flash_commit) else $error("page commit wrong");

  property p_ee_byte;
    do_wr_ee |-> (ee_we && (ee_waddr == c_addr[EE_AW-1:0]) && (ee_wdata == c_data))
                 ##1 (st_r == ST_WAIT);
  endproperty
  a_ee_byte: assert property (p_ee_byte) else $error("eeprom byte write wrong");

  property p_ee_keep;
    in_eepg && !ee_mask_r[ee_sw] |-> !ee_we;
  endproperty
  a_ee_keep: assert property (p_ee_keep) else $error("unloaded eeprom byte written");

  property p_poll;
    act_hdr_r && (h_op == OP_POLL) |-> ##2 (resp_r == {7'h00, $past(busy)});
  endproperty
  a_poll: assert property (p_poll) else $error("poll answer wrong");

  property p_read;
    act_hdr_r && h_rdfl |-> ##2 (resp_r == $past(fl_rdata));
  endproperty
  a_read: assert property (p_read) else $error("flash read answer wrong");

  property p_exit;
    pin_s2_r |=> (run_normal && !miso_oe) ##1 !enabled_r;
  endproperty
  a_exit: assert property (p_exit) else $error("programming mode not left");
endmodule : isp_port

// ===== rtl/isp_pkg.sv
package isp_pkg;

  localparam int CLK_HZ = 20_000_000;

  // largest variant; the others use 16 or 32 words with 64 pages
  localparam int FLASH_PAGE_WORDS = 32;
  localparam int FLASH_PAGES      = 128;
  localparam int WORD_IDX_W       = $clog2(FLASH_PAGE_WORDS);
  localparam int PAGE_IDX_W       = $clog2(FLASH_PAGES);
  localparam int FLASH_WORD_AW    = WORD_IDX_W + PAGE_IDX_W;
  localparam int FLASH_BYTE_AW    = FLASH_WORD_AW + 1;
  localparam int FLASH_BYTES      = 1 << FLASH_BYTE_AW;
  localparam int FBUF_AW          = WORD_IDX_W + 1;
  localparam int FBUF_BYTES       = 2 * FLASH_PAGE_WORDS;

  localparam int EE_PAGE_BYTES    = 4;
  localparam int EE_BYTE_IDX_W    = 2;
  localparam int EE_PAGES         = 128;
  localparam int EE_AW            = EE_BYTE_IDX_W + $clog2(EE_PAGES);
  localparam int EE_BYTES         = 1 << EE_AW;

  localparam int SWEEP_W = FLASH_BYTE_AW;
  localparam logic [SWEEP_W-1:0] ERASE_LAST   = SWEEP_W'(FLASH_BYTES - 1);
  localparam logic [SWEEP_W-1:0] FBUF_LAST    = SWEEP_W'(FBUF_BYTES);
  localparam logic [SWEEP_W-1:0] EE_PAGE_LAST = SWEEP_W'(EE_PAGE_BYTES - 1);
  localparam logic [SWEEP_W-1:0] EE_LIMIT     = SWEEP_W'(EE_BYTES);

  localparam logic [7:0] OP_PROG_EN     = 8'hAC;
  localparam logic [7:0] OP_PE_SECOND   = 8'h53;
  localparam logic [7:0] OP_ERASE_SEC   = 8'h80;
  localparam logic [7:0] OP_POLL        = 8'hF0;
  localparam logic [7:0] OP_LOAD_LO     = 8'h40;
  localparam logic [7:0] OP_LOAD_HI     = 8'h48;
  localparam logic [7:0] OP_LOAD_EE     = 8'hC1;
  localparam logic [7:0] OP_READ_LO     = 8'h20;
  localparam logic [7:0] OP_READ_HI     = 8'h28;
  localparam logic [7:0] OP_READ_EE     = 8'hA0;
  localparam logic [7:0] OP_WR_PAGE     = 8'h4C;
  localparam logic [7:0] OP_WR_EE       = 8'hC0;
  localparam logic [7:0] OP_WR_EE_PAGE  = 8'hC2;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;

  // bit counter positions in the 32-bit frame
  localparam logic [4:0] HDR_LAST_BIT = 5'h17;
  localparam logic [4:0] CMD_LAST_BIT = 5'h1F;
  localparam logic [4:0] ECHO_SLOT    = 5'h10;
  localparam logic [4:0] RESP_SLOT    = 5'h18;

  localparam real FLASH_PAGE_WRITE_WAIT_MS = 4.5;
  localparam real EEPROM_WRITE_WAIT_MS     = 4.0;
  localparam real CHIP_ERASE_WAIT_MS       = 4.0;
  localparam int FLASH_WAIT_CYC =
    int'($ceil(FLASH_PAGE_WRITE_WAIT_MS * real'(CLK_HZ) / 1000.0));
  localparam int EE_WAIT_CYC =
    int'($ceil(EEPROM_WRITE_WAIT_MS * real'(CLK_HZ) / 1000.0));
  localparam int ERASE_WAIT_CYC =
    int'($ceil(CHIP_ERASE_WAIT_MS * real'(CLK_HZ) / 1000.0));
  localparam int WAIT_W = 17;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ERASE    = 3'b001,
    ST_FLASH_WR = 3'b010,
    ST_EE_PAGE  = 3'b011,
    ST_WAIT     = 3'b100
  } isp_state_type;

endpackage : isp_pkg

// ===== rtl/isp_link_if.sv
`timescale 1ns/1ns
interface isp_link_if;
  logic [23:0] hdr_word;
  logic        hdr_tog;
  logic [31:0] cmd_word;
  logic        cmd_tog;
  logic [7:0]  resp_byte;
  logic        link_clear;

  modport link (output hdr_word, hdr_tog, cmd_word, cmd_tog,
                input  resp_byte, link_clear);
  modport core (input  hdr_word, hdr_tog, cmd_word, cmd_tog,
                output resp_byte, link_clear);
endinterface : isp_link_if

// ===== rtl/isp_mem.sv
`timescale 1ns/1ns
module isp_mem #(
  parameter int AW = 8,
  parameter int DW = 8
)
(
  // write port
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // registered read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
    rdata <= mem_r[raddr];
  end
endmodule : isp_mem

// ===== rtl/isp_link.sv
`timescale 1ns/1ns
module isp_link
  import isp_pkg::*;
(
  // serial pins, clocked by the programmer
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  // core side
  isp_link_if.link  lk
);
  logic [4:0]  cnt_r;
  logic [30:0] rx_r;
  logic [7:0]  tx_r;
  wire  [31:0] rx_full   = {rx_r, mosi};
  wire         byte_edge = (cnt_r[2:0] == 3'h0);
  wire         resp_slot = (cnt_r == RESP_SLOT);

  // link_clear comes from a clk flop and only moves while sck idles
  always_ff @(posedge sck or posedge lk.link_clear)
  begin
    if (lk.link_clear)
    begin
      cnt_r       <= 5'h00;
      rx_r        <= 31'h00000000;
      lk.hdr_word <= 24'h000000;
      lk.hdr_tog  <= 1'b0;
      lk.cmd_word <= 32'h00000000;
      lk.cmd_tog  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 5'h01;
      rx_r  <= rx_full[30:0];
      if (cnt_r == HDR_LAST_BIT)
      begin
        lk.hdr_word <= rx_full[23:0];
        lk.hdr_tog  <= ~lk.hdr_tog;
      end
      if (cnt_r == CMD_LAST_BIT)
      begin
        lk.cmd_word <= rx_full;
        lk.cmd_tog  <= ~lk.cmd_tog;
      end
    end
  end

  // each byte goes out msb first; byte 4 carries the core's answer
  always_ff @(negedge sck or posedge lk.link_clear)
  begin
    if (lk.link_clear)
      tx_r <= 8'h00;
    else if (byte_edge)
      tx_r <= resp_slot ? lk.resp_byte : rx_r[7:0];
    else
      tx_r <= {tx_r[6:0], 1'b0};
  end

  assign miso = tx_r[7];

  property p_echo;
    @(negedge sck) disable iff (lk.link_clear)
    (cnt_r == ECHO_SLOT) |=> (tx_r == $past(rx_r[7:0]));
  endproperty
  a_echo: assert property (p_echo) else $error("byte 2 not echoed in byte 3");
endmodule : isp_link

// ===== tb/isp_programmer.sv
`timescale 1ns/1ns
module isp_programmer
(
  // link clock from the bench
  input  wire logic lclk,
  // serial pins
  input  wire logic miso,
  output logic      sck,
  output logic      mosi
);
  // sck stands low between frames
  initial
  begin
    sck  = 1'b0;
    mosi = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge lclk);
  endtask : ticks

  // whole frame, msb first; returns bytes three and four as seen on miso
  task automatic frame(input logic [31:0] cmd, output logic [7:0] b3, output logic [7:0] b4);
    logic [31:0] rx;
    rx = '0;
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge lclk);
      mosi <= cmd[i];
      ticks(4);
      rx[i] = miso;
      sck <= 1'b1;
      // long high phase after the 24th edge gives the core time to answer
      ticks((i == 8) ? 9 : 4);
      sck <= 1'b0;
    end
    ticks(8);
    b3 = rx[15:8];
    b4 = rx[7:0];
  endtask : frame
endmodule : isp_programmer

// ===== tb/isp_port_tb.sv
`timescale 1ns/1ns
module isp_port_tb
  import isp_pkg::*;
;
  logic       clk;
  logic       lclk;
  logic       reset;
  logic       reset_pin_n;
  logic       sck;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic       miso_line;
  logic       idle_r;
  logic       prog_enabled;
  logic       write_pending_flag;
  logic       run_normal;
  logic [7:0] r3;
  logic [7:0] r4;
  int         n_fail;
  int         tests_run;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // link clock, unrelated phase
  initial
  begin
    lclk = 1'b0;
    #11;
    forever #24 lclk = ~lclk;
  end

  // undriven miso shows a changing level, never a stale bit
  always_ff @(posedge clk)
  begin
    if (reset)
      idle_r <= 1'b0;
    else
      idle_r <= ~idle_r;
  end
  assign miso_line = miso_oe ? miso : idle_r;

  isp_port #(.FLASH_WAIT(16), .EE_WAIT(16), .ERASE_WAIT(16)) i_dut
  (
    .clk                (clk),
    .reset              (reset),
    .reset_pin_n        (reset_pin_n),
    .sck                (sck),
    .mosi               (mosi),
    .miso               (miso),
    .miso_oe            (miso_oe),
    .prog_enabled       (prog_enabled),
    .write_pending_flag (write_pending_flag),
    .run_normal         (run_normal)
  );

  isp_programmer i_prog
  (
    .lclk (lclk),
    .miso (miso_line),
    .sck  (sck),
    .mosi (mosi)
  );

  task automatic finish_test();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic send(input logic [31:0] cmd);
    i_prog.frame(cmd, r3, r4);
    @(negedge clk);
  endtask : send

  task automatic poll_done();
    int n;
    n = 0;
    send({OP_POLL, 24'h0});
    while (r4[0] !== 1'b0 && n < 100)
    begin
      send({OP_POLL, 24'h0});
      n++;
    end
    check("poll", r4[0], 8'h00);
  endtask : poll_done

  task automatic pin(input logic lvl);
    @(posedge clk);
    reset_pin_n <= lvl;
    repeat (5) @(negedge clk);
  endtask : pin

  task automatic enable_ok();
    send({OP_PROG_EN, OP_PE_SECOND, 16'h0});
    check("echo", r3, OP_PE_SECOND);
    repeat (4) @(negedge clk);
    check("enabled", prog_enabled, 8'h01);
  endtask : enable_ok

  task automatic t_refused();
    check("oe", miso_oe, 8'h01);
    check("normal", run_normal, 8'h00);
    send({OP_PROG_EN, OP_ERASE_SEC, 16'h0});
    check("busy", write_pending_flag, 8'h00);
    check("enabled", prog_enabled, 8'h00);
    enable_ok();
  endtask : t_refused

  task automatic t_erase();
    send({OP_PROG_EN, OP_ERASE_SEC, 16'h0});
    check("busy", write_pending_flag, 8'h01);
    send({OP_POLL, 24'h0});
    check("poll", r4[0], 8'h01);
    poll_done();
    send({OP_READ_HI, 16'h0FFF, 8'h00});
    check("flash", r4, ERASED_BYTE);
    send({OP_READ_EE, 16'h01FF, 8'h00});
    check("ee", r4, ERASED_BYTE);
  endtask : t_erase

  task automatic t_flash();
    logic [15:0] wa;
    for (int w = 0; w < 32; w += 31)
    begin
      wa = 16'(5 * 32 + w);
      send({OP_LOAD_LO, wa, 8'(8'h10 + w)});
      send({OP_LOAD_HI, wa, 8'(8'h90 + w)});
    end
    // any word inside the page selects it
    send({OP_WR_PAGE, 16'(5 * 32 + 7), 8'h00});
    check("busy", write_pending_flag, 8'h01);
    poll_done();
    for (int w = 0; w < 32; w += 31)
    begin
      wa = 16'(5 * 32 + w);
      send({OP_READ_LO, wa, 8'h00});
      check("flash lo", r4, 8'(8'h10 + w));
      send({OP_READ_HI, wa, 8'h00});
      check("flash hi", r4, 8'(8'h90 + w));
    end
    send({OP_READ_LO, 16'(5 * 32 + 1), 8'h00});
    check("flash gap", r4, ERASED_BYTE);
    send({OP_READ_LO, 16'(4 * 32 + 31), 8'h00});
    check("flash other", r4, ERASED_BYTE);
  endtask : t_flash

  task automatic t_ee();
    send({OP_WR_EE, 16'h0009, 8'h00});
    poll_done();
    // a second write sets bits back to one only if it erased first
    send({OP_WR_EE, 16'h0009, 8'hA5});
    check("busy", write_pending_flag, 8'h01);
    poll_done();
    send({OP_READ_EE, 16'h0009, 8'h00});
    check("ee byte", r4, 8'hA5);
    send({OP_LOAD_EE, 16'h000A, 8'h5A});
    send({OP_WR_EE_PAGE, 16'h0008, 8'h00});
    poll_done();
    for (int a = 8; a < 12; a++)
    begin
      send({OP_READ_EE, 16'(a), 8'h00});
      check("ee page", r4, (a == 9) ? 8'hA5 : (a == 10) ? 8'h5A : ERASED_BYTE);
    end
  endtask : t_ee

  task automatic t_session();
    pin(1'b1);
    check("normal", run_normal, 8'h01);
    check("enabled", prog_enabled, 8'h00);
    check("oe", miso_oe, 8'h00);
    pin(1'b0);
    send({OP_WR_EE, 16'h0009, 8'h00});
    check("busy", write_pending_flag, 8'h00);
    enable_ok();
    send({OP_READ_EE, 16'h0009, 8'h00});
    check("ee kept", r4, 8'hA5);
  endtask : t_session

  initial
  begin
    n_fail      = 0;
    tests_run   = 0;
    reset       = 1'b1;
    reset_pin_n = 1'b0;
    repeat (16) @(negedge clk);
    check("normal", run_normal, 8'h01);
    check("oe", miso_oe, 8'h00);
    check("busy", write_pending_flag, 8'h00);
    @(posedge clk);
    reset <= 1'b0;
    // scaled-down power-up pause before the first frame, an erase sent before enable
    repeat (6) @(negedge clk);
    t_refused();
    t_erase();
    t_flash();
    t_ee();
    t_session();
    finish_test();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : isp_port_tb
